// ===== cfc_channel_function_config.v
// per-channel function configuration command interpreter
`timescale 1ns/1ps
`include "cfc_consts.vh"

module cfc_channel_function_config #(
  parameter MS_CYCLES = `CFC_MS_PS / `CFC_CLK_PERIOD_PS,
  parameter NCH = 64,
  parameter CNT_W = 24
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [NCH*8-1:0] dig_in_i,
  input wire [15:0] plugon_kind_i,
  input wire adc_valid_i,
  input wire [5:0] adc_chan_i,
  input wire [15:0] adc_data_i,
  output wire armed_state_o,
  output wire overrange_o,
  output wire busy_o
);

  // ==========================================================
  // state codes
  localparam S_IDLE = 3'd0;
  localparam S_EXEC = 3'd1;
  localparam S_DIV = 3'd2;
  localparam S_FIN = 3'd3;
  localparam S_CLR = 3'd4;
  localparam [31:0] MS_LAST = MS_CYCLES - 1;

  // ==========================================================
  // storage
  reg [2:0] state_r;
  reg [3:0] op_r;
  reg auto_r;
  reg [15:0] chan_r;
  reg [31:0] param_r;
  reg [31:0] result_r;
  reg [15:0] err_code_r;
  reg err_flag_r;
  reg armed_r;
  reg ovr_r;
  reg any_remote_r;
  reg [1:0] func_r [0:NCH-1];
  reg [2:0] range_r [0:NCH-1];
  reg [9:0] gate_r [0:NCH-1];
  reg [NCH:0] tbl_ok_r;
  reg [NCH:0] tbl_pw_r;
  reg [15:0] tbl_rng_r [0:NCH];
  reg [3:0] rem_r [0:`CFC_REM_COUNT-1];
  reg [12:0] clr_idx_r;
  reg [47:0] quo_r;
  reg [9:0] rem_div_r;
  reg [9:0] den_r;
  reg [5:0] div_cnt_r;
  reg float_r;
  reg [31:0] tick_cnt_r;
  reg tick_r;
  reg [NCH*8-1:0] dsync1_r;
  reg [NCH*8-1:0] dsync2_r;
  reg [15:0] ksync1_r;
  reg [15:0] ksync2_r;
  wire [NCH*CNT_W-1:0] fres_cnt_w;
  wire [NCH*10-1:0] fres_gate_w;
  integer i;
  integer j;

  assign armed_state_o = armed_r;
  assign overrange_o = ovr_r;
  assign busy_o = (state_r != S_IDLE);

  // ==========================================================
  // pin synchronisers and the 1 ms tick
  always @(posedge clk_i) begin
    dsync1_r <= dig_in_i;
    dsync2_r <= dsync1_r;
    ksync1_r <= plugon_kind_i;
    ksync2_r <= ksync1_r;
    if (rst_i) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r >= MS_LAST) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r <= 1'b0;
    end
  end

  // ==========================================================
  // per-channel gate counters
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_freq
      reg prev_r;
      reg [9:0] ms_r;
      reg [CNT_W-1:0] cnt_r;
      reg [CNT_W-1:0] res_r;
      reg [9:0] rgate_r;
      wire run = armed_r && (func_r[g] == `CFC_FN_FREQ);
      wire s = dsync2_r[g*8];
      wire [CNT_W-1:0] cnt_inc = cnt_r + {{(CNT_W-1){1'b0}}, s & ~prev_r};
      always @(posedge clk_i) begin
        if (rst_i) begin
          prev_r <= 1'b0;
          ms_r <= 10'h000;
          cnt_r <= {CNT_W{1'b0}};
          res_r <= {CNT_W{1'b0}};
          rgate_r <= 10'h000;
        end else if (!run) begin
          prev_r <= s;
          ms_r <= 10'h000;
          cnt_r <= {CNT_W{1'b0}};
        end else begin
          prev_r <= s;
          if (tick_r && (ms_r + 10'h001 >= gate_r[g])) begin
            res_r <= cnt_inc;
            rgate_r <= gate_r[g];
            ms_r <= 10'h000;
            cnt_r <= {CNT_W{1'b0}};
          end else begin
            if (tick_r)
              ms_r <= ms_r + 10'h001;
            if (~&cnt_r)
              cnt_r <= cnt_inc;
          end
        end
      end
      assign fres_cnt_w[g*CNT_W +: CNT_W] = res_r;
      assign fres_gate_w[g*10 +: 10] = rgate_r;
    end
  endgenerate

  // ==========================================================
  // channel decode and parameter checks
  wire is_loc = (chan_r >= `CFC_LOC_FIRST) && (chan_r <= `CFC_LOC_LAST);
  wire is_rem = (chan_r >= `CFC_REM_FIRST) && (chan_r <= `CFC_REM_LAST);
  wire [15:0] loc_full = chan_r - `CFC_LOC_FIRST;
  wire [5:0] lidx = loc_full[5:0];
  wire [15:0] rem_full = chan_r - `CFC_REM_FIRST;
  wire [12:0] ridx = rem_full[12:0];
  wire [1:0] kind = ksync2_r[lidx[5:3]*2 +: 2];
  wire is_dig = (kind == `CFC_PO_DIG8) || (kind == `CFC_PO_DIG1);
  wire gate_ok = (param_r[31:10] == 22'h000000) &&
                 (param_r[9:0] >= `CFC_GATE_MIN) &&
                 (param_r[9:0] <= `CFC_GATE_MAX);

  reg [2:0] rng_code;
  reg rng_bad;
  always @* begin
    rng_bad = 1'b0;
    if (auto_r)
      rng_code = `CFC_RNG_AUTO;
    else if (param_r <= `CFC_RNG_TH0)
      rng_code = 3'h0;
    else if (param_r <= `CFC_RNG_TH1)
      rng_code = 3'h1;
    else if (param_r <= `CFC_RNG_TH2)
      rng_code = 3'h2;
    else if (param_r <= `CFC_RNG_TH3)
      rng_code = 3'h3;
    else if (param_r <= `CFC_RNG_TH4)
      rng_code = 3'h4;
    else begin
      rng_code = 3'h0;
      rng_bad = 1'b1;
    end
  end

  // arm check: custom local channel, or any remote channel setting, without a table
  reg arm_bad;
  always @* begin
    arm_bad = any_remote_r && !tbl_ok_r[NCH];
    for (i = 0; i < NCH; i = i + 1)
      if (func_r[i] == `CFC_FN_CUSTOM && !tbl_ok_r[i])
        arm_bad = 1'b1;
  end

  // leading one of the quotient for float packing
  function [5:0] lead_one;
    input [47:0] v;
    integer k;
    begin
      lead_one = 6'd0;
      for (k = 0; k < 48; k = k + 1)
        if (v[k])
          lead_one = k[5:0];
    end
  endfunction

  wire [5:0] lpos = lead_one(quo_r);
  wire [47:0] mshift = quo_r >> (lpos - 6'd23);
  wire [7:0] fexp = {2'b00, lpos} + 8'd93;
  wire [10:0] rem_t = {rem_div_r, quo_r[47]};
  wire rem_ge = rem_t >= {1'b0, den_r};
  wire [10:0] rem_sub = rem_t - {1'b0, den_r};
  wire [CNT_W-1:0] fcnt = fres_cnt_w[lidx*CNT_W +: CNT_W];
  wire [9:0] fgate = fres_gate_w[lidx*10 +: 10];
  wire [7:0] dstate = (kind == `CFC_PO_DIG8) ? dsync2_r[lidx*8 +: 8] :
                      {7'h00, dsync2_r[lidx*8]};

  // ==========================================================
  // bus access strobes
  wire acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = acc && wb_we_i && (&wb_sel_i);
  wire cmd_wr = wr && (wb_adr_i == `CFC_REG_CMD) && (state_r == S_IDLE);
  wire err_wr = wr && (wb_adr_i == `CFC_REG_ERR);

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        if (wb_adr_i == `CFC_REG_CMD)
          wb_dat_o <= {28'h0000000, ovr_r, err_flag_r, armed_r,
                       state_r != S_IDLE};
        else if (wb_adr_i == `CFC_REG_CHAN)
          wb_dat_o <= {16'h0000, chan_r};
        else if (wb_adr_i == `CFC_REG_PARAM)
          wb_dat_o <= param_r;
        else if (wb_adr_i == `CFC_REG_RESULT)
          wb_dat_o <= result_r;
        else if (wb_adr_i == `CFC_REG_ERR)
          wb_dat_o <= {15'h0000, err_flag_r, err_code_r};
        else
          wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // command engine
  // an error sets code and flag; a clear in the same cycle loses
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= S_CLR;
      clr_idx_r <= 13'h0000;
      op_r <= 4'h0;
      auto_r <= 1'b0;
      chan_r <= 16'h0000;
      param_r <= 32'h0000_0000;
      result_r <= 32'h0000_0000;
      err_code_r <= 16'h0000;
      err_flag_r <= 1'b0;
      armed_r <= 1'b0;
      ovr_r <= 1'b0;
      any_remote_r <= 1'b0;
      quo_r <= 48'h0000_0000_0000;
      rem_div_r <= 10'h000;
      den_r <= 10'h000;
      div_cnt_r <= 6'h00;
      float_r <= 1'b0;
      tbl_ok_r <= {(NCH+1){1'b0}};
      tbl_pw_r <= {(NCH+1){1'b0}};
      for (j = 0; j < NCH; j = j + 1) begin
        func_r[j] <= `CFC_FN_DEFAULT;
        range_r[j] <= `CFC_RNG_AUTO;
        gate_r[j] <= `CFC_GATE_RST;
      end
      for (j = 0; j <= NCH; j = j + 1)
        tbl_rng_r[j] <= 16'h0000;
    end else begin
      if (err_wr) begin
        err_flag_r <= 1'b0;
        err_code_r <= 16'h0000;
        ovr_r <= 1'b0;
      end
      if (wr && wb_adr_i == `CFC_REG_CHAN && state_r == S_IDLE)
        chan_r <= wb_dat_i[15:0];
      if (wr && wb_adr_i == `CFC_REG_PARAM && state_r == S_IDLE)
        param_r <= wb_dat_i;
      if (adc_valid_i && func_r[adc_chan_i] == `CFC_FN_CUSTOM &&
          tbl_pw_r[adc_chan_i] && adc_data_i > tbl_rng_r[adc_chan_i])
        ovr_r <= 1'b1;
      case (state_r)
        S_CLR: begin
          // remote settings live in a memory, so reset sweeps it
          rem_r[clr_idx_r] <= {1'b0, `CFC_RNG_AUTO};
          clr_idx_r <= clr_idx_r + 13'h0001;
          if (clr_idx_r == `CFC_REM_COUNT - 1)
            state_r <= S_IDLE;
        end
        S_IDLE: begin
          if (cmd_wr) begin
            op_r <= wb_dat_i[3:0];
            auto_r <= wb_dat_i[`CFC_CMD_AUTO_BIT];
            state_r <= S_EXEC;
          end
        end
        S_EXEC: begin
          state_r <= S_IDLE;
          case (op_r)
            `CFC_OP_SET_GATE, `CFC_OP_QRY_GATE, `CFC_OP_FUNC_FREQ,
            `CFC_OP_QRY_FREQ: begin
              if (!is_loc) begin
                err_code_r <= `CFC_ERR_CHAN;
                err_flag_r <= 1'b1;
              end else if (kind != `CFC_PO_DIG1) begin
                err_code_r <= `CFC_ERR_NO_HW;
                err_flag_r <= 1'b1;
              end else if (op_r == `CFC_OP_SET_GATE) begin
                if (gate_ok)
                  gate_r[lidx] <= param_r[9:0];
                else begin
                  err_code_r <= `CFC_ERR_RANGE;
                  err_flag_r <= 1'b1;
                end
              end else if (op_r == `CFC_OP_FUNC_FREQ) begin
                func_r[lidx] <= `CFC_FN_FREQ;
              end else if (op_r == `CFC_OP_QRY_GATE) begin
                quo_r <= {38'h0, gate_r[lidx]} << `CFC_FLOAT_SHIFT;
                den_r <= `CFC_GATE_MAX;
                float_r <= 1'b1;
                div_cnt_r <= 6'h00;
                rem_div_r <= 10'h000;
                state_r <= S_DIV;
              end else if (fgate == 10'h000) begin
                result_r <= 32'h0000_0000;
              end else begin
                quo_r <= {{(48-CNT_W){1'b0}}, fcnt} * 48'd1000;
                den_r <= fgate;
                float_r <= 1'b0;
                div_cnt_r <= 6'h00;
                rem_div_r <= 10'h000;
                state_r <= S_DIV;
              end
            end
            `CFC_OP_FUNC_COND, `CFC_OP_QRY_STATE: begin
              if (!is_loc || !is_dig) begin
                err_code_r <= `CFC_ERR_NO_HW;
                err_flag_r <= 1'b1;
              end else if (op_r == `CFC_OP_FUNC_COND)
                func_r[lidx] <= `CFC_FN_COND;
              else
                result_r <= {24'h000000, dstate};
            end
            `CFC_OP_FUNC_CUSTOM, `CFC_OP_FUNC_HVOLT: begin
              if (armed_r) begin
                err_code_r <= `CFC_ERR_ARMED;
                err_flag_r <= 1'b1;
              end else if (rng_bad) begin
                err_code_r <= `CFC_ERR_RANGE;
                err_flag_r <= 1'b1;
              end else if (op_r == `CFC_OP_FUNC_HVOLT) begin
                if (is_rem) begin
                  rem_r[ridx] <= {1'b1, rng_code};
                  any_remote_r <= 1'b1;
                end else begin
                  err_code_r <= `CFC_ERR_CHAN;
                  err_flag_r <= 1'b1;
                end
              end else if (is_loc) begin
                func_r[lidx] <= `CFC_FN_CUSTOM;
                range_r[lidx] <= rng_code;
              end else if (is_rem) begin
                rem_r[ridx] <= {1'b1, rng_code};
                any_remote_r <= 1'b1;
              end else begin
                err_code_r <= `CFC_ERR_CHAN;
                err_flag_r <= 1'b1;
              end
            end
            `CFC_OP_LOAD_LIN, `CFC_OP_LOAD_PIECE: begin
              if (is_loc || is_rem) begin
                tbl_ok_r[is_loc ? lidx : NCH] <= 1'b1;
                tbl_pw_r[is_loc ? lidx : NCH] <=
                  (op_r == `CFC_OP_LOAD_PIECE);
                tbl_rng_r[is_loc ? lidx : NCH] <= param_r[15:0];
              end else begin
                err_code_r <= `CFC_ERR_CHAN;
                err_flag_r <= 1'b1;
              end
            end
            `CFC_OP_ARM: begin
              if (arm_bad) begin
                err_code_r <= `CFC_ERR_NO_TABLE;
                err_flag_r <= 1'b1;
              end else
                armed_r <= 1'b1;
            end
            `CFC_OP_DISARM: armed_r <= 1'b0;
            `CFC_OP_QRY_CFG: begin
              if (is_loc)
                result_r <= {24'h000000, 1'b0, range_r[lidx],
                             2'b00, func_r[lidx]};
              else if (is_rem)
                result_r <= {24'h000000, 1'b0, rem_r[ridx][2:0],
                             1'b0, rem_r[ridx][3], 2'b00};
              else begin
                err_code_r <= `CFC_ERR_CHAN;
                err_flag_r <= 1'b1;
              end
            end
            default: begin
              err_code_r <= `CFC_ERR_CHAN;
              err_flag_r <= 1'b1;
            end
          endcase
        end
        S_DIV: begin
          // restoring division, one quotient bit per cycle
          quo_r <= {quo_r[46:0], rem_ge};
          rem_div_r <= rem_ge ? rem_sub[9:0] : rem_t[9:0];
          div_cnt_r <= div_cnt_r + 6'h01;
          if (div_cnt_r == 6'd47)
            state_r <= S_FIN;
        end
        S_FIN: begin
          // mantissa truncated, not rounded
          if (float_r)
            result_r <= {1'b0, fexp, mshift[22:0]};
          else
            result_r <= quo_r[31:0];
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule // cfc_channel_function_config

// ===== cfc_consts.vh
// constants for the channel function configuration block
`ifndef CFC_CONSTS_VH
`define CFC_CONSTS_VH
// ==========================================================
// register byte offsets
`define CFC_REG_CMD 8'h00
`define CFC_REG_CHAN 8'h04
`define CFC_REG_PARAM 8'h08
`define CFC_REG_RESULT 8'h0C
`define CFC_REG_ERR 8'h10
// ==========================================================
// command word fields and opcodes
`define CFC_CMD_AUTO_BIT 8
`define CFC_OP_SET_GATE 4'h1
`define CFC_OP_QRY_GATE 4'h2
`define CFC_OP_FUNC_FREQ 4'h3
`define CFC_OP_FUNC_COND 4'h4
`define CFC_OP_FUNC_CUSTOM 4'h5
`define CFC_OP_FUNC_HVOLT 4'h6
`define CFC_OP_LOAD_LIN 4'h7
`define CFC_OP_LOAD_PIECE 4'h8
`define CFC_OP_ARM 4'h9
`define CFC_OP_DISARM 4'hA
`define CFC_OP_QRY_STATE 4'hB
`define CFC_OP_QRY_FREQ 4'hC
`define CFC_OP_QRY_CFG 4'hD
// ==========================================================
// channel numbering
`define CFC_LOC_FIRST 16'd100
`define CFC_LOC_LAST 16'd163
`define CFC_REM_FIRST 16'd10000
`define CFC_REM_LAST 16'd15731
`define CFC_REM_COUNT 5732
// ==========================================================
// functions, plug-on kinds, ranges (16.16 volts thresholds)
`define CFC_FN_DEFAULT 2'h0
`define CFC_FN_COND 2'h1
`define CFC_FN_FREQ 2'h2
`define CFC_FN_CUSTOM 2'h3
`define CFC_PO_ANALOG 2'h0
`define CFC_PO_DIG8 2'h1
`define CFC_PO_DIG1 2'h2
`define CFC_RNG_AUTO 3'h5
`define CFC_RNG_TH0 32'h0000_1000
`define CFC_RNG_TH1 32'h0000_4000
`define CFC_RNG_TH2 32'h0001_0000
`define CFC_RNG_TH3 32'h0004_0000
`define CFC_RNG_TH4 32'h0010_0000
// ==========================================================
// gate time in ms, error codes, timing
`define CFC_GATE_MIN 10'd1
`define CFC_GATE_MAX 10'd1000
`define CFC_GATE_RST 10'd1
`define CFC_ERR_RANGE 16'hFF22
`define CFC_ERR_ARMED 16'hFF23
`define CFC_ERR_NO_HW 16'hFF0F
`define CFC_ERR_NO_TABLE 16'hFF2C
`define CFC_ERR_CHAN 16'hFF24
`define CFC_CLK_PERIOD_PS 5000
`define CFC_MS_PS 1000000000
`define CFC_FLOAT_SHIFT 34
`endif

// ===== cfc_frontend_model.sv
// front-end model: plug-on kinds, digital inputs, converter readings
`timescale 1ns/1ps
module cfc_frontend_model #(
  parameter NCH = 64
) (
  input wire clk_i,
  input wire fire_i,
  input wire [5:0] chan_i,
  input wire [15:0] data_i,
  output wire [NCH*8-1:0] dig_in_o,
  output wire [15:0] plugon_kind_o,
  output reg adc_valid_o,
  output reg [5:0] adc_chan_o,
  output reg [15:0] adc_data_o
);
  // ==========================================================
  // plug-on layout and digital patterns
  // slot 0 analog, slot 1 byte digital, slot 2 single-bit, rest empty
  assign plugon_kind_o = 16'hFFE4;
  reg [NCH*8-1:0] pat_r;
  reg [7:0] cnt_r;
  integer n;
  initial begin
    cnt_r = 8'h00;
    adc_valid_o = 1'b0;
    adc_chan_o = 6'h00;
    adc_data_o = 16'h0000;
    for (n = 0; n < NCH; n = n + 1) begin
      pat_r[n*8 +: 8] = n[7:0] ^ 8'hA5;
    end
  end
  // channel 16 bit 0 toggles with period 4 cycles for counting
  assign dig_in_o = {pat_r[NCH*8-1:129], cnt_r[1], pat_r[127:0]};
  // ==========================================================
  // converter strobe; idle lines show inverted stale values
  always @(posedge clk_i) begin
    cnt_r <= cnt_r + 8'h01;
    adc_valid_o <= fire_i;
    adc_chan_o <= fire_i ? chan_i : ~adc_chan_o;
    adc_data_o <= fire_i ? data_i : ~adc_data_o;
  end
endmodule // cfc_frontend_model

// ===== cfc_channel_function_config_checker.sv
// port-level assertions for the function configuration block
`timescale 1ns/1ps
module cfc_checker (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire adc_valid_i,
  input wire armed_state_o,
  input wire overrange_o,
  input wire busy_o
);
  // ==========================================================
  // helper: cycles since the last command write
  wire cmd_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
    wb_adr_i == 8'h00;
  reg [3:0] age_r;
  always @(posedge clk_i) begin
    if (rst_i) age_r <= 4'hF;
    else if (cmd_wr) age_r <= 4'h0;
    else if (age_r != 4'hF) age_r <= age_r + 4'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // properties
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_unmapped;
    wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h20) |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_status;
    wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h00) |->
      wb_dat_o[1:0] == {$past(armed_state_o), $past(busy_o)} &&
      wb_dat_o[3] == $past(overrange_o);
  endproperty
  a_status: assert property (p_status) else $error("status mismatch");
  property p_reset;
    $fell(rst_i) |-> (busy_o && !armed_state_o && !overrange_o) [*8];
  endproperty
  a_reset: assert property (p_reset) else $error("reset state");
  property p_armed_cmd;
    $changed(armed_state_o) |-> age_r < 4'h6;
  endproperty
  a_armed_cmd: assert property (p_armed_cmd) else $error("armed drift");
  property p_over_cause;
    $rose(overrange_o) |-> $past(adc_valid_i, 1) || $past(adc_valid_i, 2);
  endproperty
  a_over_cause: assert property (p_over_cause) else $error("overrange");
  property p_over_sticky;
    overrange_o && !(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h10)
      |=> overrange_o;
  endproperty
  a_over_sticky: assert property (p_over_sticky) else $error("lost");
  c_armed: cover property ($rose(armed_state_o));
  c_over: cover property ($rose(overrange_o));
  c_unmapped: cover property (wb_ack_o && $past(wb_adr_i == 8'h20));
endmodule // cfc_checker

// ===== tb_cfc_channel_function_config.sv
// self-checking bench for the channel function configuration block
`timescale 1ns/1ps
`include "cfc_consts.vh"
module tb_cfc_channel_function_config;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0;
  reg [31:0] q;
  reg fire = 1'b0;
  reg [15:0] fdat = 16'h0;
  reg [5:0] fch = 6'h00;
  wire [31:0] rdat;
  wire ack, armed, over, busy, av;
  wire [511:0] dig;
  wire [15:0] kind, adat;
  wire [5:0] ach;
  int bad_count = 0;
  int compares = 0;
  int i;
  logic [31:0] rv [10] = '{32'h0, 32'h1000, 32'h1001, 32'h4000, 32'h10000,
    32'h40000, 32'h41999, 32'h100000, 32'h100001, 32'h0};
  logic [2:0] rc [10] = '{0, 0, 1, 1, 2, 3, 4, 4, 4, 5};
  always #2.5 clk_i = ~clk_i;
  // ==========================================================
  // design and front-end model; short ms tick keeps gates brief
  cfc_channel_function_config #(.MS_CYCLES(20)) i_cfc_channel_function_config (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .dig_in_i(dig), .plugon_kind_i(kind),
    .adc_valid_i(av), .adc_chan_i(ach), .adc_data_i(adat),
    .armed_state_o(armed), .overrange_o(over), .busy_o(busy));
  cfc_frontend_model i_cfc_frontend_model (
    .clk_i(clk_i), .fire_i(fire), .chan_i(fch), .data_i(fdat),
    .dig_in_o(dig), .plugon_kind_o(kind), .adc_valid_o(av),
    .adc_chan_o(ach), .adc_data_o(adat));
  // ==========================================================
  // tasks
  task wrap_up;
    begin
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      compares++;
      if (got !== exp) begin
        bad_count++;
        $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // classic cycle: hold until ack is sampled, then one idle cycle
  task wb(input bit w, input [7:0] a, input [31:0] d);
    int n;
    begin
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
        @(posedge clk_i);
        n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) chk("ack", 32'h1, 32'h0);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task wait_idle;
    int n;
    begin
      n = 0;
      do begin
        wb(1'b0, `CFC_REG_CMD, 32'h0);
        n++;
      end while (q[0] !== 1'b0 && n < 4000);
      if (q[0] !== 1'b0) chk("busy", 32'h0, 32'h1);
    end
  endtask
  task cmd(input [3:0] op, input [15:0] ch, input [31:0] p, input bit au);
    begin
      wb(1'b1, `CFC_REG_CHAN, {16'h0, ch});
      wb(1'b1, `CFC_REG_PARAM, p);
      wb(1'b1, `CFC_REG_CMD, {23'h0, au, 4'h0, op});
      wait_idle;
    end
  endtask
  // reads and clears the error register
  task chk_err(input [16:0] exp, input [16:0] m);
    begin
      wb(1'b0, `CFC_REG_ERR, 32'h0);
      chk("error", {15'h0, exp}, {15'h0, q[16:0] & m});
      wb(1'b1, `CFC_REG_ERR, 32'h0);
    end
  endtask
  task qry(input [3:0] op, input [15:0] ch, input [31:0] m, input [31:0] e);
    begin
      cmd(op, ch, 32'h0, 1'b0);
      wb(1'b0, `CFC_REG_RESULT, 32'h0);
      chk("result", e, q & m);
    end
  endtask
  task do_reset;
    begin
      rst_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_idle;
    end
  endtask
  task adc(input [5:0] c, input [15:0] d);
    begin
      fire <= 1'b1;
      fch <= c;
      fdat <= d;
      @(posedge clk_i);
      fire <= 1'b0;
      repeat (3) @(posedge clk_i);
      wb(1'b0, `CFC_REG_CMD, 32'h0);
    end
  endtask
  // ==========================================================
  // watchdog and test sequence
  initial begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    wrap_up;
  end
  initial begin
    do_reset;
    chk("status", 32'h0, q & 32'hF);
    wb(1'b1, 8'h20, 32'hFFFFFFFF);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    qry(`CFC_OP_QRY_GATE, 16'd116, 32'hFFFFFFFF, 32'h3A83126E);
    cmd(`CFC_OP_SET_GATE, 16'd116, 32'd1000, 1'b0);
    chk_err(17'h0, 17'h1FFFF);
    cmd(`CFC_OP_SET_GATE, 16'd116, 32'd1001, 1'b0);
    chk_err(17'h1FF22, 17'h1FFFF);
    cmd(`CFC_OP_SET_GATE, 16'd116, 32'd0, 1'b0);
    chk_err(17'h1FF22, 17'h1FFFF);
    qry(`CFC_OP_QRY_GATE, 16'd116, 32'hFFFFFFFF, 32'h3F800000);
    cmd(`CFC_OP_SET_GATE, 16'd100, 32'd2, 1'b0);
    chk_err(17'h1FF0F, 17'h1FFFF);
    cmd(`CFC_OP_FUNC_FREQ, 16'd108, 32'h0, 1'b0);
    chk_err(17'h1FF0F, 17'h1FFFF);
    cmd(`CFC_OP_FUNC_COND, 16'd100, 32'h0, 1'b0);
    chk_err(17'h10000, 17'h10000);
    cmd(`CFC_OP_FUNC_COND, 16'd108, 32'h0, 1'b0);
    chk_err(17'h0, 17'h1FFFF);
    qry(`CFC_OP_QRY_STATE, 16'd108, 32'hFFFFFFFF, 32'hAD);
    qry(`CFC_OP_QRY_STATE, 16'd118, 32'hFFFFFFFF, 32'h1);
    for (i = 0; i < 10; i++) begin
      cmd(`CFC_OP_FUNC_CUSTOM, 16'd100, rv[i], i == 9);
      chk_err(i == 8 ? 17'h1FF22 : 17'h0, 17'h1FFFF);
      qry(`CFC_OP_QRY_CFG, 16'd100, 32'h73, {25'h0, rc[i], 4'h3});
    end
    cmd(`CFC_OP_FUNC_HVOLT, 16'd100, 32'h0, 1'b1);
    chk_err(17'h10000, 17'h10000);
    cmd(`CFC_OP_FUNC_HVOLT, 16'd15731, 32'h10000, 1'b0);
    chk_err(17'h0, 17'h1FFFF);
    qry(`CFC_OP_QRY_CFG, 16'd15731, 32'h74, 32'h24);
    cmd(`CFC_OP_ARM, 16'd100, 32'h0, 1'b0);
    chk_err(17'h1FF2C, 17'h1FFFF);
    cmd(`CFC_OP_DISARM, 16'd100, 32'h0, 1'b0);
    cmd(`CFC_OP_FUNC_FREQ, 16'd116, 32'h0, 1'b0);
    cmd(`CFC_OP_SET_GATE, 16'd116, 32'd2, 1'b0);
    cmd(`CFC_OP_LOAD_PIECE, 16'd100, 32'h100, 1'b0);
    cmd(`CFC_OP_LOAD_LIN, 16'd15731, 32'h0, 1'b0);
    cmd(`CFC_OP_ARM, 16'd100, 32'h0, 1'b0);
    chk_err(17'h0, 17'h1FFFF);
    chk("armed", 32'h1, {31'h0, armed});
    cmd(`CFC_OP_FUNC_CUSTOM, 16'd101, 32'h0, 1'b1);
    chk_err(17'h1FF23, 17'h1FFFF);
    cmd(`CFC_OP_FUNC_HVOLT, 16'd10000, 32'h0, 1'b1);
    chk_err(17'h1FF23, 17'h1FFFF);
    adc(6'd16, 16'hFFFF);
    chk("over", 32'h0, q & 32'h8);
    adc(6'd0, 16'h0100);
    chk("over", 32'h0, q & 32'h8);
    adc(6'd0, 16'h0101);
    chk("over", 32'h8, q & 32'h8);
    chk_err(17'h0, 17'h1FFFF);
    wb(1'b0, `CFC_REG_CMD, 32'h0);
    chk("over", 32'h0, q & 32'h8);
    repeat (150) @(posedge clk_i);
    qry(`CFC_OP_QRY_FREQ, 16'd116, 32'hFFFFFFFF, 32'd5000);
    cmd(`CFC_OP_DISARM, 16'd100, 32'h0, 1'b0);
    // mid-run reset must drop gates, bindings and tables
    do_reset;
    qry(`CFC_OP_QRY_GATE, 16'd116, 32'hFFFFFFFF, 32'h3A83126E);
    cmd(`CFC_OP_FUNC_CUSTOM, 16'd100, 32'h0, 1'b1);
    cmd(`CFC_OP_ARM, 16'd100, 32'h0, 1'b0);
    chk_err(17'h1FF2C, 17'h1FFFF);
    wrap_up;
  end
endmodule // tb_cfc_channel_function_config
bind cfc_channel_function_config cfc_checker i_cfc_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .adc_valid_i(adc_valid_i),
  .armed_state_o(armed_state_o), .overrange_o(overrange_o),
  .busy_o(busy_o));
